/* logic/lcrd_defines.svh */
// Summary of operation
// RL1 - bias on, release node, wait 1000 us, then step level every 100 us until comparator low
// RL2 - stored reference level is the step found plus the reference margin
// RL3 - clamp sense node after its level is found; bias off after both channels
// RL4 - until calibrated, track lowest and highest pulse count on every measurement
// RL5 - countdown from 4; with enough spread, odd steps need low count, even steps high count
// RL6 - the recommended minimum spread setting is 3
// RL7 - turn tally stays unchanged until threshold calibration is finished
// RL8 - before trigger: bias on, release nodes, select comparator, apply level, wait stable plus 10 us
// RL9 - enable pulse counting, then pulse the channel trigger high for one cycle; the code sets both in the same cycle
// RL10 - after trigger wait 10 us, poll counter every 10 us until two equal readings
// RL11 - threshold is (lowest + highest) >> 1; channel one count above it sets bit 0x1
// RL12 - channel two sets phase bit 0x2; phase cleared before each sampling round
// RL13 - after each measurement drive sense and clamp nodes low until the next trigger
// RL14 - 00->01 decrement, 01->00 increment, 00<->11 or 01<->10 error, others nothing
// RL15 - transition table: one 16-bit word per previous phase, nibble chosen by new phase
// RL16 - decrement or increment turn tally, or increment fault tally, each raising an alert
// RL17 - each sample decides from previous and new phase, then stores new as previous
// RL18 - sampling round every sample_period_ticks 4 kHz ticks, default 40
`ifndef LCRD_DEFINES_SVH
`define LCRD_DEFINES_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LCRD_CLK_HZ 20000000
`define LCRD_TICK_HZ 4000
`define LCRD_SETTLE_US 1000
`define LCRD_STEP_US 100
`define LCRD_GAP_US 10
`define LCRD_SETTLE_CYC ((`LCRD_SETTLE_US * (`LCRD_CLK_HZ / 1000000)))
`define LCRD_STEP_CYC ((`LCRD_STEP_US * (`LCRD_CLK_HZ / 1000000)))
`define LCRD_GAP_CYC ((`LCRD_GAP_US * (`LCRD_CLK_HZ / 1000000)))
`define LCRD_TICK_CYC ((`LCRD_CLK_HZ / `LCRD_TICK_HZ))

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define LCRD_OFS_CONTROL 8'h00
`define LCRD_OFS_MARGIN 8'h04
`define LCRD_OFS_PERIOD 8'h08
`define LCRD_OFS_STATUS 8'h0c
`define LCRD_OFS_MASK 8'h10
`define LCRD_OFS_TURN 8'h14
`define LCRD_OFS_FAULT 8'h18
`define LCRD_OFS_PHASE 8'h1c
`define LCRD_OFS_REF 8'h20
`define LCRD_OFS_MEAS 8'h24

// ----------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------
`define LCRD_MARGIN_RST 8'h04
`define LCRD_SPREAD_RST 16'h0003
`define LCRD_PERIOD_RST 16'h0028
`define LCRD_COUNTDOWN_RST 3'h4
`define LCRD_ST_DOWN 0
`define LCRD_ST_UP 1
`define LCRD_ST_FAULT 2
`define LCRD_ST_CAL 3
`define LCRD_ACT_DOWN 4'h1
`define LCRD_ACT_UP 4'h2
`define LCRD_ACT_FAULT 4'h4
`define LCRD_TABLE_0 16'h4010
`define LCRD_TABLE_1 16'h0402
`define LCRD_TABLE_2 16'h0040
`define LCRD_TABLE_3 16'h0004
`define LCRD_RESP_OKAY 2'h0
`define LCRD_RESP_SLVERR 2'h2

`endif

/* logic/lcrd_pkg.sv */
package lcrd_pkg;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_RC_SETTLE = 4'h1,
    ST_RC_STEP = 4'h2,
    ST_WAIT = 4'h3,
    ST_PREP = 4'h4,
    ST_GAP = 4'h5,
    ST_TRIG = 4'h6,
    ST_POLL_FIRST = 4'h7,
    ST_POLL = 4'h8,
    ST_DECODE = 4'h9
  } lcrd_state_t;

  // ----------------------------------------------------------------
  // analogue front-end pins, all driven from one register
  // ----------------------------------------------------------------
  typedef struct packed {
    logic bias_power;
    logic [1:0] sense_release;
    logic [1:0] clamp_release;
    logic comp_select;
    logic [1:0] trigger;
    logic [7:0] reference_level;
  } lcrd_pins_t;

endpackage : lcrd_pkg

/* logic/lcrd_top.sv */
`timescale 1ns/1ns
`include "lcrd_defines.svh"

module lcrd_top #(
  parameter int SETTLE_CYCLES = `LCRD_SETTLE_CYC,
  parameter int TICK_CYCLES = `LCRD_TICK_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sense_comparator,
  input wire logic reference_stable,
  output lcrd_pkg::lcrd_pins_t pins,
  output logic irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam logic [15:0] STEP_CYC = 16'(`LCRD_STEP_CYC);
  localparam logic [15:0] GAP_CYC = 16'(`LCRD_GAP_CYC);
  localparam logic [15:0] SETTLE_C = 16'(SETTLE_CYCLES);
  localparam logic [15:0] TICK_C = 16'(TICK_CYCLES);

  lcrd_pkg::lcrd_state_t state_q;
  lcrd_pkg::lcrd_pins_t pins_q;
  logic [15:0] wait_q;
  logic ch_q;
  logic enable_q;
  logic [7:0] reference_margin_q;
  logic [15:0] spread_q;
  logic [15:0] sample_period_ticks_q;
  logic [3:0] status_q;
  logic [3:0] mask_q;
  logic irq_q;
  logic [15:0] turn_tally_q;
  logic [15:0] fault_tally_q;
  logic [1:0] disc_phase_q;
  logic [1:0] previous_phase_q;
  logic [7:0] channel_reference_level_q [2];
  logic [15:0] lowest_count_q [2];
  logic [15:0] highest_count_q [2];
  logic [2:0] calibration_countdown_q [2];
  logic [15:0] meas_q [2];
  logic [15:0] pulse_cnt_q;
  logic [15:0] prev_cnt_q;
  logic pcnt_en_q;
  logic comp_q;
  logic [15:0] presc_q;
  logic [15:0] tick_cnt_q;

  // ----------------------------------------------------------------
  // axi4-lite handshake bookkeeping
  // ----------------------------------------------------------------
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // address and data may arrive in either order; commit once both are held
  wire aw_take = s_axi_awvalid & awready_q;
  wire w_take = s_axi_wvalid & wready_q;
  wire wr_go = aw_have_q & w_have_q & ~bvalid_q;
  wire aw_have_d = (aw_have_q & ~wr_go) | aw_take;
  wire w_have_d = (w_have_q & ~wr_go) | w_take;
  wire bvalid_d = (bvalid_q & ~s_axi_bready) | wr_go;
  wire ar_take = s_axi_arvalid & arready_q;
  wire rvalid_d = (rvalid_q & ~s_axi_rready) | ar_take;
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] wbits = wdata_q & wmask;
  wire wr_ctrl = wr_go & (awaddr_q == `LCRD_OFS_CONTROL);
  wire wr_margin = wr_go & (awaddr_q == `LCRD_OFS_MARGIN);
  wire wr_period = wr_go & (awaddr_q == `LCRD_OFS_PERIOD);
  wire wr_status = wr_go & (awaddr_q == `LCRD_OFS_STATUS);
  wire wr_mask = wr_go & (awaddr_q == `LCRD_OFS_MASK);
  wire wr_hit = wr_ctrl | wr_margin | wr_period | wr_status | wr_mask;

  // read decode; unmapped offsets read zero with a slave error
  wire [7:0] ra = s_axi_araddr;
  wire rd_hit = (ra[1:0] == 2'h0) & (ra <= `LCRD_OFS_MEAS);
  wire [31:0] rd_word =
    (ra == `LCRD_OFS_CONTROL) ? {31'h0, enable_q} :
    (ra == `LCRD_OFS_MARGIN) ? {8'h0, spread_q, reference_margin_q} :
    (ra == `LCRD_OFS_PERIOD) ? {16'h0, sample_period_ticks_q} :
    (ra == `LCRD_OFS_STATUS) ? {28'h0, status_q} :
    (ra == `LCRD_OFS_MASK) ? {28'h0, mask_q} :
    (ra == `LCRD_OFS_TURN) ? {16'h0, turn_tally_q} :
    (ra == `LCRD_OFS_FAULT) ? {16'h0, fault_tally_q} :
    (ra == `LCRD_OFS_PHASE) ? {16'h0, 1'b0, calibration_countdown_q[1], 1'b0,
                               calibration_countdown_q[0], 4'h0, previous_phase_q,
                               disc_phase_q} :
    (ra == `LCRD_OFS_REF) ? {16'h0, channel_reference_level_q[1], channel_reference_level_q[0]} :
    (ra == `LCRD_OFS_MEAS) ? {meas_q[1], meas_q[0]} : 32'h0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `LCRD_RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awready_q <= ~aw_have_d & ~bvalid_d;
      wready_q <= ~w_have_d & ~bvalid_d;
      bvalid_q <= bvalid_d;
      if (aw_take)
        awaddr_q <= s_axi_awaddr;
      if (w_take)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go)
        bresp_q <= wr_hit ? `LCRD_RESP_OKAY : `LCRD_RESP_SLVERR;
    end
  end

  // read channel: one outstanding read, data latched at the address handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `LCRD_RESP_OKAY;
    end
    else
    begin
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_take)
      begin
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? `LCRD_RESP_OKAY : `LCRD_RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      enable_q <= 1'b0;
      reference_margin_q <= `LCRD_MARGIN_RST;
      spread_q <= `LCRD_SPREAD_RST; // RL6
      sample_period_ticks_q <= `LCRD_PERIOD_RST; // RL18
      mask_q <= 4'h0;
    end
    else
    begin
      if (wr_ctrl)
        enable_q <= (enable_q & ~wmask[0]) | wbits[0];
      if (wr_margin)
      begin
        reference_margin_q <= (reference_margin_q & ~wmask[7:0]) | wbits[7:0];
        spread_q <= (spread_q & ~wmask[23:8]) | wbits[23:8];
      end
      if (wr_period)
        sample_period_ticks_q <= (sample_period_ticks_q & ~wmask[15:0]) | wbits[15:0];
      if (wr_mask)
        mask_q <= (mask_q & ~wmask[3:0]) | wbits[3:0];
    end
  end

  // ----------------------------------------------------------------
  // measurement arithmetic for the active channel
  // ----------------------------------------------------------------
  wire [15:0] cur_lo = lowest_count_q[ch_q];
  wire [15:0] cur_hi = highest_count_q[ch_q];
  wire [2:0] cur_cd = calibration_countdown_q[ch_q];
  wire [16:0] thr_sum = {1'b0, cur_lo} + {1'b0, cur_hi};
  wire [15:0] threshold = thr_sum[16:1]; // RL11
  wire [15:0] meas = pulse_cnt_q;
  wire [15:0] new_lo = (meas < cur_lo) ? meas : cur_lo; // RL4
  wire [15:0] new_hi = (meas > cur_hi) ? meas : cur_hi; // RL4
  wire [16:0] mid_sum = {1'b0, new_lo} + {1'b0, new_hi};
  wire [15:0] mid = mid_sum[16:1];
  wire [15:0] half = {1'b0, spread_q[15:1]};
  wire spread_ok = (16'(new_hi - new_lo) >= spread_q);
  // odd countdown asks for a low reading, even for a high one
  wire cd_hit = spread_ok & (cur_cd[0] ? (meas < 16'(mid - half)) : (meas > 16'(mid + half))); // RL5
  wire poll_done = (state_q == lcrd_pkg::ST_POLL) & (wait_q == 16'h0) & (pulse_cnt_q == prev_cnt_q); // RL10
  wire cal_done = (calibration_countdown_q[0] == 3'h0) & (calibration_countdown_q[1] == 3'h0);

  // per-channel calibration storage
  genvar g;
  for (g = 0; g < 2; g++)
  begin : g_chan
    wire sel = (ch_q == 1'(g));
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        lowest_count_q[g] <= 16'hffff;
        highest_count_q[g] <= 16'h0000;
        calibration_countdown_q[g] <= `LCRD_COUNTDOWN_RST; // RL5
        meas_q[g] <= 16'h0;
      end
      else if (poll_done & sel)
      begin
        meas_q[g] <= meas;
        if (calibration_countdown_q[g] != 3'h0)
        begin
          lowest_count_q[g] <= new_lo; // RL4
          highest_count_q[g] <= new_hi; // RL4
          if (cd_hit)
            calibration_countdown_q[g] <= calibration_countdown_q[g] - 3'h1; // RL5
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // transition decode
  // ----------------------------------------------------------------
  wire [15:0] table_word =
    (previous_phase_q == 2'h0) ? `LCRD_TABLE_0 :
    (previous_phase_q == 2'h1) ? `LCRD_TABLE_1 :
    (previous_phase_q == 2'h2) ? `LCRD_TABLE_2 : `LCRD_TABLE_3; // RL15
  wire [15:0] table_shift = table_word >> {disc_phase_q, 2'b00};
  wire [3:0] step_verdict = table_shift[3:0]; // RL14 RL15
  wire decoding = (state_q == lcrd_pkg::ST_DECODE);
  wire act_down = decoding & (step_verdict == `LCRD_ACT_DOWN);
  wire act_up = decoding & (step_verdict == `LCRD_ACT_UP);
  wire act_fault = decoding & (step_verdict == `LCRD_ACT_FAULT);
  wire [3:0] status_set = {decoding & cal_done, act_fault, act_up, act_down};
  wire [3:0] status_clr = wr_status ? wbits[3:0] : 4'h0;
  wire [3:0] status_d = (status_q & ~status_clr) | status_set; // a new event beats the clear

  // tallies, phase history and alert status
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      turn_tally_q <= 16'h0;
      fault_tally_q <= 16'h0;
      previous_phase_q <= 2'h0;
      status_q <= 4'h0;
      irq_q <= 1'b0;
    end
    else
    begin
      status_q <= status_d; // RL16
      irq_q <= |(status_d & mask_q);
      if (decoding)
        previous_phase_q <= disc_phase_q; // RL17
      if (act_down & cal_done)
        turn_tally_q <= turn_tally_q - 16'h1; // RL7 RL16
      else if (act_up & cal_done)
        turn_tally_q <= turn_tally_q + 16'h1; // RL7 RL16
      if (act_fault)
        fault_tally_q <= fault_tally_q + 16'h1; // RL16
    end
  end

  // ----------------------------------------------------------------
  // sample pacing and pulse counter
  // ----------------------------------------------------------------
  wire tick = (presc_q == 16'h0);
  wire round_go = (state_q == lcrd_pkg::ST_WAIT) & (tick_cnt_q >= sample_period_ticks_q); // RL18

  // comparator is synchronous, so its previous value serves as the edge reference
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      presc_q <= 16'h0;
      tick_cnt_q <= 16'h0;
      comp_q <= 1'b0;
      pulse_cnt_q <= 16'h0;
    end
    else
    begin
      presc_q <= tick ? 16'(TICK_C - 16'h1) : 16'(presc_q - 16'h1);
      if (round_go)
        tick_cnt_q <= 16'h0;
      else if (tick & (tick_cnt_q != 16'hffff))
        tick_cnt_q <= tick_cnt_q + 16'h1;
      comp_q <= sense_comparator;
      if (!pcnt_en_q)
        pulse_cnt_q <= 16'h0;
      else if (sense_comparator & ~comp_q)
        pulse_cnt_q <= pulse_cnt_q + 16'h1; // RL9
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  wire wait_end = (wait_q == 16'h0);

  // one shared down-counter times the settle, step, gap and poll delays; the level step also saturates
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= lcrd_pkg::ST_IDLE;
      pins_q <= '0;
      wait_q <= 16'h0;
      ch_q <= 1'b0;
      pcnt_en_q <= 1'b0;
      prev_cnt_q <= 16'h0;
      disc_phase_q <= 2'h0;
      channel_reference_level_q[0] <= 8'h0;
      channel_reference_level_q[1] <= 8'h0;
    end
    else
    begin
      if (!wait_end)
        wait_q <= wait_q - 16'h1;
      case (state_q)
        lcrd_pkg::ST_IDLE:
        begin
          if (enable_q)
          begin
            pins_q.bias_power <= 1'b1; // RL1
            pins_q.sense_release <= 2'b01; // RL1
            pins_q.comp_select <= 1'b0;
            pins_q.reference_level <= 8'h0;
            ch_q <= 1'b0;
            wait_q <= 16'(SETTLE_C - 16'h1); // RL1
            state_q <= lcrd_pkg::ST_RC_SETTLE;
          end
        end
        lcrd_pkg::ST_RC_SETTLE:
        begin
          if (wait_end)
          begin
            pins_q.reference_level <= pins_q.reference_level + 8'h1; // RL1
            wait_q <= 16'(STEP_CYC - 16'h1); // RL1
            state_q <= lcrd_pkg::ST_RC_STEP;
          end
        end
        lcrd_pkg::ST_RC_STEP:
        begin
          if (wait_end & (~sense_comparator | (pins_q.reference_level == 8'hff)))
          begin
            channel_reference_level_q[ch_q] <= pins_q.reference_level + reference_margin_q; // RL2
            pins_q.sense_release[ch_q] <= 1'b0; // RL3
            if (ch_q)
            begin
              pins_q.bias_power <= 1'b0; // RL3
              pins_q.reference_level <= 8'h0;
              state_q <= lcrd_pkg::ST_WAIT;
            end
            else
            begin
              ch_q <= 1'b1;
              pins_q.sense_release[1] <= 1'b1;
              pins_q.comp_select <= 1'b1;
              pins_q.reference_level <= 8'h0;
              wait_q <= 16'(SETTLE_C - 16'h1); // RL1
              state_q <= lcrd_pkg::ST_RC_SETTLE;
            end
          end
          else if (wait_end)
          begin
            pins_q.reference_level <= pins_q.reference_level + 8'h1; // RL1
            wait_q <= 16'(STEP_CYC - 16'h1);
          end
        end
        lcrd_pkg::ST_WAIT:
        begin
          if (round_go)
          begin
            disc_phase_q <= 2'h0; // RL12
            ch_q <= 1'b0;
            pins_q.bias_power <= 1'b1; // RL8
            pins_q.clamp_release <= 2'b01; // RL8
            pins_q.sense_release <= 2'b01; // RL8
            pins_q.comp_select <= 1'b0; // RL8
            pins_q.reference_level <= channel_reference_level_q[0]; // RL8
            state_q <= lcrd_pkg::ST_PREP;
          end
        end
        lcrd_pkg::ST_PREP:
        begin
          if (reference_stable)
          begin
            wait_q <= 16'(GAP_CYC - 16'h1); // RL8
            state_q <= lcrd_pkg::ST_GAP;
          end
        end
        lcrd_pkg::ST_GAP:
        begin
          if (wait_end)
          begin
            pcnt_en_q <= 1'b1; // RL9
            pins_q.trigger[ch_q] <= 1'b1; // RL9
            state_q <= lcrd_pkg::ST_TRIG;
          end
        end
        lcrd_pkg::ST_TRIG:
        begin
          pins_q.trigger <= 2'b00; // RL9
          wait_q <= 16'(GAP_CYC - 16'h1); // RL10
          state_q <= lcrd_pkg::ST_POLL_FIRST;
        end
        lcrd_pkg::ST_POLL_FIRST:
        begin
          if (wait_end)
          begin
            prev_cnt_q <= 16'h0;
            wait_q <= 16'(GAP_CYC - 16'h1); // RL10
            state_q <= lcrd_pkg::ST_POLL;
          end
        end
        lcrd_pkg::ST_POLL:
        begin
          if (poll_done)
          begin
            pcnt_en_q <= 1'b0;
            if (meas > threshold)
              disc_phase_q[ch_q] <= 1'b1; // RL11 RL12
            pins_q.sense_release <= 2'b00; // RL13
            pins_q.clamp_release <= 2'b00; // RL13
            if (ch_q)
              state_q <= lcrd_pkg::ST_DECODE;
            else
            begin
              ch_q <= 1'b1;
              pins_q.clamp_release <= 2'b10; // RL8
              pins_q.sense_release <= 2'b10; // RL8
              pins_q.comp_select <= 1'b1; // RL8
              pins_q.reference_level <= channel_reference_level_q[1]; // RL8
              state_q <= lcrd_pkg::ST_PREP;
            end
          end
          else if (wait_end)
          begin
            prev_cnt_q <= pulse_cnt_q; // RL10
            wait_q <= 16'(GAP_CYC - 16'h1);
          end
        end
        lcrd_pkg::ST_DECODE:
        begin
          pins_q.bias_power <= 1'b0;
          state_q <= lcrd_pkg::ST_WAIT; // RL17
        end
        default:
        begin
          state_q <= lcrd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pins = pins_q;
  assign irq = irq_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule : lcrd_top

/* verif/lcrd_top_asserts.sv */
`timescale 1ns/1ns
module lcrd_top_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire lcrd_pkg::lcrd_pins_t pins
);
  // ----------------------------------------
  // front-end pin ordering
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // a moving reference upsets the count, so no trigger soon after a change
  sequence s_quiet;
    (pins.trigger == 2'h0) [*8];
  endsequence
  sequence s_held;
    pins.sense_release[pins.comp_select] [*8];
  endsequence
  property p_pulse; |pins.trigger |=> pins.trigger == 2'h0; endproperty
  a_pulse: assert property (p_pulse) else $error("trigger too wide");
  property p_bias; |pins.trigger |-> pins.bias_power; endproperty
  a_bias: assert property (p_bias) else $error("trigger unpowered");
  property p_rel; |pins.trigger |-> pins.sense_release[pins.comp_select] && pins.clamp_release[pins.comp_select]; endproperty
  a_rel: assert property (p_rel) else $error("trigger on held node");
  property p_sel; |pins.trigger |-> pins.trigger == (2'h1 << pins.comp_select); endproperty
  a_sel: assert property (p_sel) else $error("wrong channel routed");
  property p_lvl; $changed(pins.reference_level) |=> s_quiet; endproperty
  a_lvl: assert property (p_lvl) else $error("level not settled");
  property p_meas; |pins.trigger |=> s_held; endproperty
  a_meas: assert property (p_meas) else $error("count cut short");
  property p_clamp; $fell(pins.sense_release[0]) |-> !pins.clamp_release[0]; endproperty
  a_clamp: assert property (p_clamp) else $error("clamp left open");
  property p_off; $fell(pins.bias_power) |-> pins.sense_release == 2'h0; endproperty
  a_off: assert property (p_off) else $error("bias off, node open");
endmodule : lcrd_top_asserts

bind lcrd_top lcrd_top_asserts u_lcrd_top_asserts (.aclk, .aresetn, .pins);

/* verif/lcrd_tank_model.sv */
`timescale 1ns/1ns
module lcrd_tank_model #(
  parameter int LVL = 5
) (
  input wire logic aclk,
  input wire lcrd_pkg::lcrd_pins_t pins,
  input wire logic [15:0] cnt0,
  input wire logic [15:0] cnt1,
  output logic sense_comparator,
  output logic reference_stable
);
  logic [15:0] left_q = '0;
  logic [1:0] ph_q = '0;
  logic rang_q = '0;
  // ring down: one comparator pulse per four clocks after a trigger
  always_ff @(posedge aclk)
  begin
    ph_q <= ph_q + 2'h1;
    if (|pins.trigger)
      left_q <= pins.trigger[1] ? cnt1 : cnt0;
    else if (left_q != '0 && ph_q == 2'h3)
      left_q <= left_q - 16'h1;
    if (|pins.trigger)
      rang_q <= 1'h1;
  end
  // before any ring the node sits at bias: high only below it, low if clamped or unpowered
  assign sense_comparator = rang_q ? left_q != '0 && ph_q[1] :
    pins.bias_power && |pins.sense_release && pins.reference_level < 8'(LVL);
  assign reference_stable = pins.bias_power;
endmodule : lcrd_tank_model

/* verif/lcrd_top_tb.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH %0t %h", $time, g); end end
module lcrd_top_tb;
  logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, irq, sense_comparator, reference_stable;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb = '1;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
  logic [15:0] cnt0 = 16'ha, cnt1 = 16'ha;
  lcrd_pkg::lcrd_pins_t pins;
  int n_fail = 0, num_checks = 0;
  // short settle and tick counts keep the run brief
  lcrd_top #(.SETTLE_CYCLES(20), .TICK_CYCLES(10)) u_lcrd_top (.*);
  lcrd_tank_model #(.LVL(5)) u_lcrd_tank_model (.*);
  initial
  begin
    forever #25 aclk = ~aclk;
  end
  // ----------------------------------------
  // bus and round helpers
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    while (!s_axi_rvalid) @(posedge aclk);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(rd_data, e)
  endtask : rc
  // counts above 20 read as covered, below as bare; returns after the round
  task automatic rnd(input logic [1:0] p);
    cnt0 <= p[0] ? 16'h1e : 16'ha;
    cnt1 <= p[1] ? 16'h1e : 16'ha;
    @(negedge pins.bias_power);
    @(posedge aclk);
  endtask : rnd
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // reset values, reference search, then five low/high calibration rounds
  task automatic t_cal();
    rc(8'h04, 32'h304);
    rc(8'h08, 32'h28);
    rc(8'h1c, 32'h4400);
    rd(8'h40);
    `CHK(rd_resp, 2'h2)
    wr(8'h00, 32'h1);
    @(negedge pins.bias_power);
    @(posedge aclk);
    `CHK(pins.sense_release, 2'h0)
    rc(8'h20, 32'h0909);
    for (int i = 0; i < 5; i++) rnd(i[0] ? 2'h3 : 2'h0);
    rc(8'h1c, 32'h0);
    rc(8'h14, 32'h0);
    rc(8'h18, 32'h4);
  endtask : t_cal
  // walk the disc through steps, faults and idle moves; only decrement alerts
  task automatic t_turn();
    logic [15:0] tbl[4] = '{16'h4010, 16'h0402, 16'h0040, 16'h0004};
    logic [1:0] sq[8] = '{2'h1, 2'h0, 2'h2, 2'h1, 2'h2, 2'h3, 2'h1, 2'h0};
    logic [1:0] prv = 2'h0;
    logic [15:0] turn = 16'h0;
    logic [15:0] flt = 16'h4;
    logic [3:0] act;
    wr(8'h0c, 32'hf);
    wr(8'h10, 32'h1);
    foreach (sq[i])
    begin
      rnd(sq[i]);
      act = 4'(tbl[prv] >> {sq[i], 2'h0});
      turn = turn + 16'(act == 4'h2) - 16'(act == 4'h1);
      flt = flt + 16'(act == 4'h4);
      prv = sq[i];
      `CHK(irq, act == 4'h1)
      rc(8'h14, {16'h0, turn});
      rc(8'h18, {16'h0, flt});
      // a round outlasts the period, so the next one has begun and cleared the live phase
      rc(8'h1c, {28'h0, prv, 2'h0});
      if (act == 4'h1) wr(8'h0c, 32'h1);
      `CHK(irq, 1'h0)
    end
  endtask : t_turn
  task automatic end_of_test();
    if (n_fail == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // main sequence
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    t_cal();
    t_turn();
    end_of_test();
  end
  // a hang counts as a failure
  initial
  begin
    repeat (90000) @(posedge aclk);
    n_fail++;
    end_of_test();
  end
endmodule : lcrd_top_tb
